// file: common/ars_pkg.sv
// Constants and carrier types for the converter result and input select block
package ars_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [2:0] ARS_IDX_CTRL_B     = 3'h3;
    localparam logic [2:0] ARS_IDX_RES_LO     = 3'h4;
    localparam logic [2:0] ARS_IDX_RES_HI     = 3'h5;
    localparam logic [2:0] ARS_IDX_STATUS     = 3'h6;
    localparam logic [2:0] ARS_IDX_SELECT     = 3'h7;

    // Field positions
    localparam int         ARS_SEL_REF_LSB    = 6;
    localparam int         ARS_CTRLB_BIP_BIT  = 0;
    localparam int         ARS_ST_DONE_BIT    = 0;
    localparam int         ARS_ST_BUSY_BIT    = 1;
    localparam int         ARS_ST_EARLY_BIT   = 2;
    localparam int         ARS_ST_PEND_BIT    = 3;
    localparam int         ARS_ST_RSVD_BIT    = 4;

    // Reset values
    localparam logic [7:0] ARS_SEL_RST        = 8'h00;
    localparam logic [7:0] ARS_CTRLB_RST      = 8'h00;
    localparam logic [9:0] ARS_RES_RST        = 10'h000;

    // Settling counts in converter clock cycles
    localparam logic [4:0] ARS_SETTLE_MIN_CYC = 5'h0d;
    localparam logic [4:0] ARS_SETTLE_MAX_CYC = 5'h19;

    // Channel and reference codes
    localparam logic [5:0] ARS_CH_TEMP        = 6'h22;
    localparam logic [1:0] ARS_REF_VCC        = 2'h0;
    localparam logic [1:0] ARS_REF_EXT        = 2'h1;
    localparam logic [1:0] ARS_REF_INT        = 2'h2;
    localparam logic [1:0] ARS_REF_RSVD       = 2'h3;

    // Routing handed to the analog front end
    typedef struct packed {
        logic [1:0] ref_sel;
        logic [5:0] chan_sel;
        logic       diff;
        logic       gain20;
        logic       swap;
        logic       temp_en;
        logic       ext_ref_in;
        logic       int_ref_to_pin;
    } ars_route_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] sel_tmp;
        logic [7:0] sel_act;
        logic       bip;
        logic [9:0] res;
        logic       done;
        logic       busy;
        logic [4:0] settle;
        logic       ack;
        logic [7:0] rdata;
        ars_route_t route;
    } ars_state_t;

endpackage

// file: hdl/ars_ctrl.sv
// Converter result formatting, input and reference select, register slave
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module ars_ctrl
    import ars_pkg::*;
#(
    parameter int RAW_W = 12
) (
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic [4:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    conv_start,
    input  wire logic                    conv_done,
    input  wire logic signed [RAW_W-1:0] conv_raw,
    output ars_route_t                   route,
    output logic      [9:0]              result
);

    //////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Single-ended codes are 0..7 and 0x20..0x22, all else differential
    function automatic logic ars_is_diff(input logic [5:0] ch);
        return !((ch[5:3] == 3'b000) ||
                 (ch == 6'h20) || (ch == 6'h21) || (ch == ARS_CH_TEMP));
    endfunction

    // Scale, gain and saturate a raw 1024-scaled difference
    function automatic logic [9:0] ars_format(
        input logic signed [RAW_W-1:0] raw,
        input logic                    diff,
        input logic                    g20,
        input logic                    bip
    );
        logic signed [17:0] v;
        logic signed [17:0] h;
        logic        [9:0]  r;
        v = 18'(raw);
        h = 18'sd0;
        r = 10'h000;
        if (diff && g20)
            v = v * 18'sd20;
        if (diff && bip) begin
            h = v >>> 1;
            if (h > 18'sd511)
                r = 10'h1ff;
            else if (h < -18'sd512)
                r = 10'h200;
            else
                r = h[9:0];
        end else if (v <= 18'sd0) begin
            r = 10'h000;
        end else if (v > 18'sd1023) begin
            r = 10'h3ff;
        end else begin
            r = v[9:0];
        end
        return r;
    endfunction

    // Routing decode of an active selection
    function automatic ars_route_t ars_decode(input logic [7:0] sel);
        ars_route_t rt;
        rt.ref_sel        = sel[7:ARS_SEL_REF_LSB];
        rt.chan_sel       = sel[5:0];
        rt.diff           = ars_is_diff(sel[5:0]);
        rt.gain20         = rt.diff & sel[0];
        // Offset calibration codes 0x23..0x27 are not reversible pairs
        rt.swap           = rt.diff & sel[5] &
                            (sel[5:3] != 3'b100);
        rt.temp_en        = (sel[5:0] == ARS_CH_TEMP);
        rt.ext_ref_in     = (rt.ref_sel == ARS_REF_EXT);
        rt.int_ref_to_pin = (rt.ref_sel == ARS_REF_RSVD);
        return rt;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // State and bus decode

    ars_state_t  s_q;
    ars_state_t  s_d;
    logic        bus_req;
    logic        bus_take;
    logic [2:0]  bus_idx;
    logic        wr_lane0;
    logic [9:0]  fmt_now;
    logic        clr_done;
    logic        sel_moved;

    // One wait state: the request is taken on the edge where ack is high
    assign bus_req         = avs_read | avs_write;
    assign bus_take        = bus_req & s_q.ack;
    assign bus_idx         = avs_address[4:2];
    assign wr_lane0        = avs_write & bus_take & avs_byteenable[0];
    assign avs_waitrequest = bus_req & ~s_q.ack;
    assign avs_readdata    = {24'h000000, s_q.rdata};
    assign route           = s_q.route;
    assign result          = s_q.res;

    // Result format follows the selection locked for this conversion
    assign fmt_now  = ars_format(conv_raw, s_q.route.diff,
                                 s_q.route.gain20, s_q.bip);
    assign clr_done = wr_lane0 && (bus_idx == ARS_IDX_STATUS) &&
                      avs_writedata[ARS_ST_DONE_BIT];

    //////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        s_d       = s_q;
        sel_moved = 1'b0;

        // Bus handshake and registered read data
        s_d.ack   = bus_req & ~s_q.ack;
        if (bus_req && !s_q.ack && avs_read) begin
            unique case (bus_idx)
                ARS_IDX_CTRL_B: s_d.rdata = {7'h00, s_q.bip};
                ARS_IDX_RES_LO: s_d.rdata = s_q.res[7:0];
                ARS_IDX_RES_HI: s_d.rdata = {6'h00, s_q.res[9:8]};
                ARS_IDX_STATUS: s_d.rdata = {
                    3'h0,
                    s_q.route.int_ref_to_pin,
                    s_q.settle < ARS_SETTLE_MAX_CYC,
                    s_q.settle < ARS_SETTLE_MIN_CYC,
                    s_q.busy,
                    s_q.done};
                ARS_IDX_SELECT: s_d.rdata = s_q.sel_tmp;
                default:        s_d.rdata = 8'h00;
            endcase
        end

        // Selection writes land in the software-visible copy, and pass to the active one unless busy; the bipolar bit applies at once
        if (wr_lane0 && bus_idx == ARS_IDX_SELECT)
            s_d.sel_tmp = avs_writedata[7:0];
        if (wr_lane0 && bus_idx == ARS_IDX_CTRL_B)
            s_d.bip = avs_writedata[ARS_CTRLB_BIP_BIT];

        // Busy spans from start until the completion pulse
        s_d.busy = conv_start | (s_q.busy & ~conv_done);

        // Active selection tracks the copy except while converting
        if (!s_q.busy || conv_done) begin
            s_d.sel_act = s_d.sel_tmp;
        end
        s_d.route = ars_decode(s_d.sel_act);

        // Settling window restarts on a new differential channel or ref
        if (s_d.sel_act[7:6] != s_q.sel_act[7:6])
            sel_moved = 1'b1;
        if (s_d.sel_act[5:0] != s_q.sel_act[5:0] && s_d.route.diff)
            sel_moved = 1'b1;
        if (sel_moved)
            s_d.settle = 5'h00;
        else if (s_q.settle < ARS_SETTLE_MAX_CYC)
            s_d.settle = s_q.settle + 5'h01;

        // Result update and flag; a new completion beats the clear
        if (conv_done)
            s_d.res = fmt_now;
        s_d.done = conv_done | (s_q.done & ~clr_done);
    end

    //////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q         <= '0;
            s_q.sel_tmp <= ARS_SEL_RST;
            s_q.sel_act <= ARS_SEL_RST;
            s_q.bip     <= ARS_CTRLB_RST[ARS_CTRLB_BIP_BIT];
            s_q.res     <= ARS_RES_RST;
            s_q.settle  <= ARS_SETTLE_MAX_CYC;
        end else begin
            s_q <= s_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_complete;
        conv_done;
    endsequence

    sequence s_locked;
        s_q.busy && !conv_done;
    endsequence

    // Result and flag both change at the completion edge
    a_result_update: assert property (
        s_complete |=> s_q.done && (s_q.res == $past(fmt_now)))
        else $error("result or flag not updated on completion");

    // Set wins over a clear in the same cycle
    a_done_set_wins: assert property (
        s_complete and clr_done |=> s_q.done)
        else $error("completion flag lost against clear");

    // A clear with no completion drops the flag
    a_done_clear: assert property (
        clr_done && !conv_done |=> !s_q.done)
        else $error("completion flag not cleared");

    // Single-ended input above full scale saturates
    a_single_ended: assert property (
        s_complete ##0 (!s_q.route.diff && conv_raw > 12'sd1023)
        |=> s_q.res == 10'h3ff)
        else $error("single-ended result not saturated");

    // Single-ended input below ground reads as code zero
    a_single_floor: assert property (
        s_complete ##0 (!s_q.route.diff && conv_raw < 0)
        |=> s_q.res == 10'h000)
        else $error("single-ended result below zero");

    // Unipolar differential never reports a negative difference
    a_unipolar_clamp: assert property (
        s_complete ##0 (s_q.route.diff && !s_q.bip && conv_raw < 0)
        |=> s_q.res == 10'h000)
        else $error("unipolar difference not clamped to zero");

    // Unity gain unipolar keeps the 1024 scale
    a_unipolar_scale: assert property (
        s_complete ##0 (s_q.route.diff && !s_q.route.gain20 &&
                        !s_q.bip && conv_raw == 12'sd100)
        |=> s_q.res == 10'd100)
        else $error("unipolar differential scale wrong");

    // Gain of twenty multiplies before quantising
    a_gain_twenty: assert property (
        s_complete ##0 (s_q.route.gain20 && !s_q.bip &&
                        conv_raw == 12'sd10)
        |=> s_q.res == 10'd200)
        else $error("gain of twenty not applied");

    // Negative bipolar results carry the sign in bit nine
    a_bipolar_sign: assert property (
        s_complete ##0 (s_q.route.diff && s_q.bip && conv_raw < -12'sd1)
        |=> s_q.res[9])
        else $error("bipolar negative result without sign");

    // Bipolar uses half the unipolar scale, two's complement
    a_bipolar_half: assert property (
        s_complete ##0 (s_q.route.diff && !s_q.route.gain20 &&
                        s_q.bip && conv_raw == -12'sd100)
        |=> s_q.res == 10'h3ce)
        else $error("bipolar scale not half of unipolar");

    // Bipolar select takes effect on its write and holds for two cycles
    a_bip_mode: assert property (
        wr_lane0 && bus_idx == ARS_IDX_CTRL_B &&
        avs_writedata[ARS_CTRLB_BIP_BIT]
        |=> s_q.bip [*2])
        else $error("bipolar select not taken");

    // Selection writes land in the software copy at once
    a_sel_written: assert property (
        wr_lane0 && bus_idx == ARS_IDX_SELECT
        |=> s_q.sel_tmp == $past(avs_writedata[7:0]))
        else $error("selection write not taken");

    // A start makes the block busy, which locks the selection
    a_busy_start: assert property (
        conv_start |=> s_q.busy)
        else $error("start did not set busy");

    // Active selection holds while a conversion runs
    a_sel_locked: assert property (
        s_locked |=> $stable(s_q.sel_act))
        else $error("active selection moved during conversion");

    // Pending selection takes over at the completion edge
    a_sel_release: assert property (
        s_q.busy ##0 s_complete |=> s_q.sel_act == s_q.sel_tmp)
        else $error("selection not released at completion");

    // Temperature code routes the sensor as single-ended
    a_temp_route: assert property (
        $changed(s_q.sel_act) && s_q.sel_act[5:0] == ARS_CH_TEMP
        |-> s_q.route.temp_en && !s_q.route.diff)
        else $error("temperature channel not routed");

    // Gain follows the lowest select bit on differential codes
    a_gain_decode: assert property (
        s_q.route.diff |-> s_q.route.gain20 == s_q.sel_act[0])
        else $error("gain select decode wrong");

    // Reversed pairs swap inputs and keep the gain decode
    a_swap_pair: assert property (
        s_q.route.diff && s_q.sel_act[5:3] == 3'b101
        |-> s_q.route.swap && s_q.route.gain20 == s_q.sel_act[0])
        else $error("pair reversal or gain decode wrong");

    // Early indication stays up after a restart of settling
    a_settle_window: assert property (
        $rose(s_q.settle == 5'h00)
        |-> (s_q.settle < ARS_SETTLE_MIN_CYC) [*8])
        else $error("settling indication too short");

    // External pin is an input only for code 01
    a_ref_decode: assert property (
        s_q.route.ext_ref_in |-> s_q.route.ref_sel == ARS_REF_EXT &&
                                 !s_q.route.int_ref_to_pin)
        else $error("external reference decode wrong");

    // Code 11 is flagged and never treats the pin as input
    a_ref_reserved: assert property (
        s_q.route.ref_sel == ARS_REF_RSVD
        |-> s_q.route.int_ref_to_pin && !s_q.route.ext_ref_in)
        else $error("reserved reference not flagged");

    // Register bus answers after exactly one wait state
    a_bus_wait: assert property (
        bus_req && !s_q.ack |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait state");

endmodule // ars_ctrl

// file: sim/ars_analog_model.sv
// Sequencer and analog front end model driving the converter link
`timescale 1ns/1ps
module ars_analog_model #(
    parameter int RAW_W = 12
) (
    input  wire logic               clk,
    output logic                    conv_start,
    output logic                    conv_done,
    output logic signed [RAW_W-1:0] conv_raw
);
    //////////////////////////////////////////////////////////////////////
    // Idle levels at time zero
    initial begin
        conv_start = 1'b0;
        conv_done  = 1'b0;
        conv_raw   = '0;
    end

    // One-cycle start pulse; the block locks its selection here
    task automatic start_conv();
        @(posedge clk);
        conv_start <= 1'b1;
        @(posedge clk);
        conv_start <= 1'b0;
    endtask

    // Sample is valid in the done cycle only; afterwards the inverse
    // shows, so a late capture cannot pass by luck
    task automatic finish_conv(input logic signed [RAW_W-1:0] raw,
                               input int slow);
        repeat (slow) @(posedge clk);
        conv_done <= 1'b1;
        conv_raw  <= raw;
        @(posedge clk);
        conv_done <= 1'b0;
        conv_raw  <= ~raw;
        @(posedge clk);
    endtask
endmodule // ars_analog_model

// file: sim/test_ars_ctrl.sv
// Self-checking bench for the converter result and select block
`timescale 1ns/1ps
module test_ars_ctrl;
    import ars_pkg::*;

    logic               clk = 1'b0;
    logic               arst_n = 1'b0;
    logic [4:0]         avs_address = '0;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_writedata = '0;
    logic [3:0]         avs_byteenable = '0;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic               conv_start;
    logic               conv_done;
    logic signed [11:0] conv_raw;
    ars_route_t         route;
    logic [9:0]         result;
    int                 num_errors = 0;
    int                 n_checks = 0;
    logic [7:0]         d;

    //////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 clk = ~clk;

    ars_ctrl #(.RAW_W(12)) dut (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .conv_start(conv_start), .conv_done(conv_done),
        .conv_raw(conv_raw), .route(route), .result(result));

    ars_analog_model #(.RAW_W(12)) am (
        .clk(clk), .conv_start(conv_start), .conv_done(conv_done),
        .conv_raw(conv_raw));

    //////////////////////////////////////////////////////////////////////
    // Verdict and end of run, shared with the watchdog
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] idx,
                       input logic [7:0] wd, input logic [3:0] be,
                       output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {24'h0, wd};
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        // Sampled at the rising edge, before the design updates
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            num_errors++;
            $display("BAD %0t bus hang", $time);
        end
        rd = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] v);
        logic [7:0] x;
        bus(1'b1, idx, v, 4'h1, x);
    endtask

    task automatic rdchk(input logic [2:0] idx, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, 4'h1, x);
        chk({2'b00, x}, {2'b00, e});
    endtask

    // Settle past the worst gain stage time before any conversion
    task automatic sel(input logic [7:0] v);
        wr(ARS_IDX_SELECT, v);
        repeat (26) @(posedge clk);
    endtask

    // Full conversion, result on port and in both bytes, flag cleared
    task automatic conv(input logic signed [11:0] raw, input logic [9:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        am.start_conv();
        am.finish_conv(raw, 3);
        chk(result, e);
        bus(1'b0, ARS_IDX_RES_LO, 8'h00, 4'h1, lo);
        bus(1'b0, ARS_IDX_RES_HI, 8'h00, 4'h1, hi);
        chk({hi[1:0], lo}, e);
        rdchk(ARS_IDX_STATUS, 8'h01);
        wr(ARS_IDX_STATUS, 8'h01);
        rdchk(ARS_IDX_STATUS, 8'h00);
    endtask

    //////////////////////////////////////////////////////////////////////
    // Watchdog, several times the expected run length
    initial begin
        #50us;
        num_errors++;
        $display("BAD %0t timeout", $time);
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rdchk(ARS_IDX_SELECT, 8'h00);
        rdchk(ARS_IDX_CTRL_B, 8'h00);
        chk(10'(route != '0), 10'h000);
        wr(3'h1, 8'hff);
        rdchk(3'h1, 8'h00);
        bus(1'b1, ARS_IDX_SELECT, 8'hff, 4'h0, d);
        rdchk(ARS_IDX_SELECT, 8'h00);
        wr(ARS_IDX_SELECT, 8'hff);
        rdchk(ARS_IDX_SELECT, 8'hff);
        // Single-ended range ends
        sel(8'h01);
        conv(12'sd300, 10'h12c);
        conv(12'sd2000, 10'h3ff);
        conv(-12'sd5, 10'h000);
        // Unipolar differential, both gains
        sel(8'h08);
        chk(10'({route.diff, route.gain20}), 10'h002);
        conv(12'sd100, 10'h064);
        conv(-12'sd10, 10'h000);
        sel(8'h09);
        chk(10'(route.gain20), 10'h001);
        conv(12'sd10, 10'h0c8);
        conv(12'sd60, 10'h3ff);
        sel(8'h28);
        chk(10'(route.swap), 10'h001);
        // Bipolar mode
        wr(ARS_IDX_CTRL_B, 8'h01);
        rdchk(ARS_IDX_CTRL_B, 8'h01);
        sel(8'h08);
        conv(-12'sd100, 10'h3ce);
        chk(10'(result[9]), 10'h001);
        conv(12'sd2000, 10'h1ff);
        sel(8'h09);
        conv(-12'sd100, 10'h200);
        conv(12'sd20, 10'h0c8);
        // Temperature sensor on the internal reference, single shot
        sel(8'ha2);
        chk(10'({route.temp_en, route.diff, route.ref_sel}),
            10'h00a);
        conv(12'sd300, 10'h12c);
        // Selection written mid-conversion waits for completion
        sel(8'h01);
        am.start_conv();
        wr(ARS_IDX_SELECT, 8'h41);
        rdchk(ARS_IDX_SELECT, 8'h41);
        rdchk(ARS_IDX_STATUS, 8'h02);
        chk(10'(route.ref_sel), 10'h000);
        am.finish_conv(12'sd50, 5);
        chk(10'({route.ref_sel, route.ext_ref_in}), 10'h003);
        chk(result, 10'h032);
        wr(ARS_IDX_STATUS, 8'h01);
        // Reserved reference code is flagged; settling shows at once
        wr(ARS_IDX_SELECT, 8'hc1);
        rdchk(ARS_IDX_STATUS, 8'h1c);
        repeat (26) @(posedge clk);
        chk(10'(route.int_ref_to_pin), 10'h001);
        rdchk(ARS_IDX_STATUS, 8'h10);
        sel(8'h01);
        chk(10'({route.ext_ref_in, route.int_ref_to_pin}), 10'h000);
        end_sim();
    end
endmodule // test_ars_ctrl
